// ===== design/baiu_pkg.sv
// Constants of the byte add instruction unit
package baiu_pkg;
   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam logic [15:0] OFS_ACC    = 16'h0000;
   localparam logic [15:0] OFS_STATUS = 16'h0004;
   localparam logic [15:0] OFS_BANK   = 16'h0008;
   localparam logic [15:0] OFS_CTRL   = 16'h000C;
   localparam logic [15:0] OFS_INSTR  = 16'h0010;
   localparam logic [15:0] OFS_INDEX  = 16'h0014;
   localparam int          MEM_WIN_BIT = 14;
   // ****************************************
   // Status flag and control bit positions
   // ****************************************
   localparam int FLG_C  = 0;
   localparam int FLG_DC = 1;
   localparam int FLG_Z  = 2;
   localparam int FLG_OV = 3;
   localparam int FLG_N  = 4;
   localparam int CTRL_EXT = 0;
   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0]  RST_ACC    = 8'h00;
   localparam logic [4:0]  RST_STATUS = 5'h00;
   localparam logic [3:0]  RST_BANK   = 4'h0;
   localparam logic        RST_EXT    = 1'b0;
   localparam logic [11:0] RST_INDEX  = 12'h000;
   // ****************************************
   // Instruction encodings
   // ****************************************
   localparam logic [7:0] OPC_ADD_LIT = 8'h0F;
   localparam logic [5:0] OPC_ADD_REG = 6'h09;
   localparam int         BIT_DEST    = 9;
   localparam int         BIT_ACCESS  = 8;
   // ****************************************
   // Addressing
   // ****************************************
   localparam logic [7:0] ACC_SPLIT   = 8'h80;
   localparam logic [3:0] ACC_HI_BANK = 4'hF;
   localparam logic [3:0] ACC_LO_BANK = 4'h0;
   localparam logic [7:0] IDX_LIMIT   = 8'h5F;
endpackage : baiu_pkg

// ===== design/baiu_top.sv
// Byte add instruction unit with a Wishbone register slave
//
// The register addresses and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module baiu_top #(
   parameter int AW = 16
) (
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   input  wire logic          wb_cyc_i,
   input  wire logic          wb_stb_i,
   input  wire logic          wb_we_i,
   input  wire logic [AW-1:0] wb_adr_i,
   input  wire logic [3:0]    wb_sel_i,
   input  wire logic [31:0]   wb_dat_i,
   output var  logic [31:0]   wb_dat_o,
   output var  logic          wb_ack_o
);
   // ****************************************
   // State
   // ****************************************
   logic [7:0]  acc_q;
   logic [4:0]  status_q;
   logic [3:0]  bank_q;
   logic        ext_q;
   logic [11:0] index_q;
   logic [7:0]  mem [4096];

   // ****************************************
   // Bus decode
   // ****************************************
   wire        req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire        wr       = req && wb_we_i;
   wire        lo_en    = wb_sel_i[0];
   wire [15:0] adr16    = 16'(wb_adr_i);
   wire        in_mem   = adr16[baiu_pkg::MEM_WIN_BIT];
   wire [11:0] bus_madr = adr16[13:2];
   wire        hit_acc  = !in_mem && adr16 == baiu_pkg::OFS_ACC;
   wire        hit_stat = !in_mem && adr16 == baiu_pkg::OFS_STATUS;
   wire        hit_bank = !in_mem && adr16 == baiu_pkg::OFS_BANK;
   wire        hit_ctrl = !in_mem && adr16 == baiu_pkg::OFS_CTRL;
   wire        hit_ins  = !in_mem && adr16 == baiu_pkg::OFS_INSTR;
   wire        hit_idx  = !in_mem && adr16 == baiu_pkg::OFS_INDEX;

   // ****************************************
   // Instruction decode and addressing
   // ****************************************
   wire [15:0] ins      = wb_dat_i[15:0];
   wire        ins_go   = wr && hit_ins && wb_sel_i[1:0] == 2'h3;
   wire        exe_lit  = ins_go && ins[15:8] == baiu_pkg::OPC_ADD_LIT;
   wire        exe_reg  = ins_go && ins[15:10] == baiu_pkg::OPC_ADD_REG;
   wire        dest_reg = ins[baiu_pkg::BIT_DEST];
   wire        banked   = ins[baiu_pkg::BIT_ACCESS];
   wire [7:0]  fadr     = ins[7:0];
   wire        indexed  = !banked && ext_q && fadr <= baiu_pkg::IDX_LIMIT;
   wire [3:0]  acc_bank = (fadr >= baiu_pkg::ACC_SPLIT) ? baiu_pkg::ACC_HI_BANK
                                                        : baiu_pkg::ACC_LO_BANK;
   wire [11:0] eff_adr  = banked  ? {bank_q, fadr} :
                          indexed ? 12'(index_q + {4'h0, fadr}) :
                          {acc_bank, fadr};
   wire [7:0]  reg_val  = mem[eff_adr];

   // ****************************************
   // Adder and flags
   // ****************************************
   wire [7:0]  opnd     = exe_lit ? fadr : reg_val;
   wire [8:0]  sum9     = {1'b0, acc_q} + {1'b0, opnd};
   wire [4:0]  sum_lo   = {1'b0, acc_q[3:0]} + {1'b0, opnd[3:0]};
   wire [7:0]  sum8     = sum9[7:0];
   wire        ovf      = (acc_q[7] == opnd[7]) && (sum8[7] != acc_q[7]);
   wire [4:0]  flags    = {sum8[7], ovf, sum8 == 8'h00, sum_lo[4], sum9[8]};
   wire        to_acc   = exe_lit || (exe_reg && !dest_reg);
   wire        to_mem   = exe_reg && dest_reg;

   // ****************************************
   // Read mux
   // ****************************************
   wire [31:0] rd_data  = in_mem   ? {24'h0, mem[bus_madr]} :
                          hit_acc  ? {24'h0, acc_q} :
                          hit_stat ? {27'h0, status_q} :
                          hit_bank ? {28'h0, bank_q} :
                          hit_ctrl ? {31'h0, ext_q} :
                          hit_idx  ? {20'h0, index_q} : 32'h0000_0000;

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         acc_q    <= baiu_pkg::RST_ACC;
         status_q <= baiu_pkg::RST_STATUS;
         bank_q   <= baiu_pkg::RST_BANK;
         ext_q    <= baiu_pkg::RST_EXT;
         index_q  <= baiu_pkg::RST_INDEX;
      end else begin
         wb_ack_o <= req;
         if (req && !wb_we_i) begin
            wb_dat_o <= rd_data;
         end
         if (to_acc) begin
            acc_q <= sum8;
         end else if (wr && hit_acc && lo_en) begin
            acc_q <= wb_dat_i[7:0];
         end
         if (exe_lit || exe_reg) begin
            status_q <= flags;
         end else if (wr && hit_stat && lo_en) begin
            status_q <= wb_dat_i[4:0];
         end
         if (wr && hit_bank && lo_en) begin
            bank_q <= wb_dat_i[3:0];
         end
         if (wr && hit_ctrl && lo_en) begin
            ext_q <= wb_dat_i[baiu_pkg::CTRL_EXT];
         end
         if (wr && hit_idx && wb_sel_i[1:0] == 2'h3) begin
            index_q <= wb_dat_i[11:0];
         end
      end
   end

   // Data memory, no reset
   always_ff @(posedge clk_i) begin
      if (!rst_i && to_mem) begin
         mem[eff_adr] <= sum8;
      end else if (!rst_i && wr && in_mem && lo_en) begin
         mem[bus_madr] <= wb_dat_i[7:0];
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   property p_lit_sum;
      @(posedge clk_i) disable iff (rst_i)
      exe_lit |=> acc_q == 8'($past(acc_q) + $past(wb_dat_i[7:0]));
   endproperty
   a_lit_sum: assert property (p_lit_sum) else $error("literal sum wrong");

   property p_reg_decode;
      @(posedge clk_i) disable iff (rst_i)
      (wr && hit_ins && wb_sel_i[1:0] == 2'h3 && wb_dat_i[15:10] == 6'b001001)
         |-> exe_reg ##1 wb_ack_o;
   endproperty
   a_reg_decode: assert property (p_reg_decode) else $error("add-register missed");

   property p_dest_acc;
      @(posedge clk_i) disable iff (rst_i)
      (exe_reg && !dest_reg) |=> acc_q == $past(sum8) && mem[$past(eff_adr)] == $past(reg_val);
   endproperty
   a_dest_acc: assert property (p_dest_acc) else $error("accumulator dest wrong");

   property p_dest_reg;
      @(posedge clk_i) disable iff (rst_i)
      (exe_reg && dest_reg) |=> mem[$past(eff_adr)] == $past(sum8) && $stable(acc_q);
   endproperty
   a_dest_reg: assert property (p_dest_reg) else $error("register dest wrong");

   property p_banked;
      @(posedge clk_i) disable iff (rst_i)
      (exe_reg && banked) |-> eff_adr == {bank_q, wb_dat_i[7:0]};
   endproperty
   a_banked: assert property (p_banked) else $error("bank address wrong");

   property p_access;
      @(posedge clk_i) disable iff (rst_i)
      (exe_reg && !banked && !indexed)
         |-> eff_adr[7:0] == wb_dat_i[7:0] && eff_adr[11:8] == (wb_dat_i[7] ? 4'hF : 4'h0);
   endproperty
   a_access: assert property (p_access) else $error("access bank wrong");

   property p_indexed;
      @(posedge clk_i) disable iff (rst_i)
      (exe_reg && !banked && ext_q && wb_dat_i[7:0] <= 8'h5F)
         |-> eff_adr == 12'(index_q + {4'h0, wb_dat_i[7:0]});
   endproperty
   a_indexed: assert property (p_indexed) else $error("indexed address wrong");

   property p_reg_flags;
      @(posedge clk_i) disable iff (rst_i)
      exe_reg |=> status_q[baiu_pkg::FLG_C] == $past(sum9[8])
               && status_q[baiu_pkg::FLG_Z] == ($past(sum8) == 8'h00)
               && status_q[baiu_pkg::FLG_N] == $past(sum8[7]);
   endproperty
   a_reg_flags: assert property (p_reg_flags) else $error("register flags wrong");

   property p_reg_ovdc;
      @(posedge clk_i) disable iff (rst_i)
      exe_reg |=> status_q[baiu_pkg::FLG_DC]
                     == (({1'b0, $past(acc_q[3:0])} + {1'b0, $past(reg_val[3:0])}) > 5'h0F)
               && status_q[baiu_pkg::FLG_OV]
                     == ($past(acc_q[7]) == $past(reg_val[7])
                         && status_q[baiu_pkg::FLG_N] != $past(acc_q[7]));
   endproperty
   a_reg_ovdc: assert property (p_reg_ovdc) else $error("register carry flags wrong");

   property p_lit_flags;
      @(posedge clk_i) disable iff (rst_i)
      exe_lit |=> status_q[baiu_pkg::FLG_DC] == $past(sum_lo[4])
               && status_q[baiu_pkg::FLG_OV] == $past(ovf) ##1 $stable(status_q);
   endproperty
   a_lit_flags: assert property (p_lit_flags) else $error("literal flags wrong");

   property p_lit_czn;
      @(posedge clk_i) disable iff (rst_i)
      exe_lit |=> status_q[baiu_pkg::FLG_C]
                     == (({1'b0, $past(acc_q)} + {1'b0, $past(wb_dat_i[7:0])}) > 9'h0FF)
               && status_q[baiu_pkg::FLG_Z] == (acc_q == 8'h00)
               && status_q[baiu_pkg::FLG_N] == acc_q[7];
   endproperty
   a_lit_czn: assert property (p_lit_czn) else $error("literal carry zero sign wrong");

   // Reset clears the bus handshake and the accumulator, status, control and index registers
   property p_rst_clear;
      @(posedge clk_i)
      rst_i |=> !wb_ack_o && acc_q == baiu_pkg::RST_ACC && status_q == baiu_pkg::RST_STATUS
             && ext_q == baiu_pkg::RST_EXT && index_q == baiu_pkg::RST_INDEX;
   endproperty
   a_rst_clear: assert property (p_rst_clear) else $error("reset state wrong");

   c_lit:  cover property (@(posedge clk_i) disable iff (rst_i) exe_lit && sum9[8]);
   c_wdst: cover property (@(posedge clk_i) disable iff (rst_i) exe_reg && !dest_reg && ovf);
   c_idx:  cover property (@(posedge clk_i) disable iff (rst_i) exe_reg && indexed && dest_reg);
   c_bank: cover property (@(posedge clk_i) disable iff (rst_i) exe_reg && banked && dest_reg);
endmodule : baiu_top
`default_nettype wire

// ===== verification/tb.sv
// Self-checking testbench of the byte add instruction unit
`timescale 1ns/1ps
`default_nettype none
module tb;
   typedef struct packed {
      logic [7:0]  acc;
      logic [7:0]  mv;
      logic        d;
      logic        a;
      logic [7:0]  f;
      logic [3:0]  bank;
      logic        ext;
      logic [11:0] idx;
      logic [11:0] ea;
   } baiu_row_t;
   logic        clk, rst, cyc, stb, we, ack;
   logic [15:0] adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat, got;
   logic [12:0] e;
   baiu_row_t   r;
   int          err_count, n_tests;
   // Accumulator in the high byte, literal in the low byte
   logic [15:0] lit_rows [6] = '{16'h1015, 16'hFF01, 16'h7F01, 16'h8080, 16'h0808, 16'h0000};
   baiu_row_t   reg_rows [7] = '{
      '{8'h17, 8'hC2, 1'h0, 1'h0, 8'h10, 4'h0, 1'h0, 12'h000, 12'h010},
      '{8'h80, 8'h80, 1'h1, 1'h1, 8'h34, 4'h5, 1'h0, 12'h000, 12'h534},
      '{8'h3C, 8'h44, 1'h1, 1'h0, 8'h90, 4'h0, 1'h0, 12'h000, 12'hF90},
      '{8'h0F, 8'h01, 1'h1, 1'h0, 8'h5F, 4'h0, 1'h1, 12'h200, 12'h25F},
      '{8'h01, 8'hFF, 1'h0, 1'h0, 8'h60, 4'h0, 1'h1, 12'h200, 12'h060},
      '{8'h22, 8'h11, 1'h1, 1'h1, 8'h20, 4'h3, 1'h1, 12'h200, 12'h320},
      '{8'h7F, 8'h7F, 1'h1, 1'h0, 8'h20, 4'h0, 1'h1, 12'hFF0, 12'h010}};

   baiu_top dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));

   always #2.5 clk = ~clk;

   task automatic close_out;
      if (err_count == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : close_out

   // Flags {N, OV, Z, DC, C} above the 8-bit sum
   function automatic logic [12:0] add(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] s;
      logic [4:0] h;
      s = {1'h0, a} + {1'h0, b};
      h = {1'h0, a[3:0]} + {1'h0, b[3:0]};
      return {s[7], a[7] == b[7] && s[7] != a[7], s[7:0] == 8'h00, h[4], s[8], s[7:0]};
   endfunction : add

   // One classic cycle, entered just after a rising edge
   task automatic bus(input logic w, input logic [15:0] a, input logic [15:0] d,
                      input logic [3:0] s);
      cyc  <= 1'h1;
      stb  <= 1'h1;
      we   <= w;
      adr  <= a;
      sel  <= s;
      wdat <= {16'h0000, d};
      @(posedge clk);
      while (ack !== 1'h1) begin
         @(posedge clk);
      end
      got = rdat;
      cyc <= 1'h0;
      stb <= 1'h0;
      @(posedge clk);
   endtask : bus

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      bus(1'h1, a, d, 4'hF);
   endtask : wr

   task automatic rd(input logic [15:0] a, input logic [15:0] x);
      bus(1'h0, a, 16'h0000, 4'hF);
      n_tests++;
      if (got !== {16'h0000, x}) begin
         err_count++;
         $display("BAD %0t adr %h got %h exp %h", $time, a, got, x);
      end
   endtask : rd

   initial begin
      repeat (3000) @(posedge clk);
      err_count++;
      close_out();
   end

   initial begin
      clk = 0; rst = 1; cyc = 0; stb = 0; we = 0; adr = 0; sel = 0; wdat = 0;
      err_count = 0; n_tests = 0;
      repeat (5) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      for (int i = 0; i < 6; i++) rd(16'(i * 4), 16'h0000);
      foreach (lit_rows[i]) begin
         e = add(lit_rows[i][15:8], lit_rows[i][7:0]);
         wr(baiu_pkg::OFS_ACC, 16'(lit_rows[i][15:8]));
         wr(baiu_pkg::OFS_STATUS, 16'(~e[12:8]));
         wr(baiu_pkg::OFS_INSTR, {baiu_pkg::OPC_ADD_LIT, lit_rows[i][7:0]});
         rd(baiu_pkg::OFS_ACC, 16'(e[7:0]));
         rd(baiu_pkg::OFS_STATUS, 16'(e[12:8]));
      end
      foreach (reg_rows[i]) begin
         r = reg_rows[i];
         e = add(r.acc, r.mv);
         wr(baiu_pkg::OFS_BANK, 16'(r.bank));
         wr(baiu_pkg::OFS_CTRL, 16'(r.ext));
         wr(baiu_pkg::OFS_INDEX, 16'(r.idx));
         wr(baiu_pkg::OFS_ACC, 16'(r.acc));
         wr({2'h1, r.ea, 2'h0}, 16'(r.mv));
         wr(baiu_pkg::OFS_STATUS, 16'(~e[12:8]));
         wr(baiu_pkg::OFS_INSTR, {baiu_pkg::OPC_ADD_REG, r.d, r.a, r.f});
         rd(baiu_pkg::OFS_ACC, 16'(r.d ? r.acc : e[7:0]));
         rd({2'h1, r.ea, 2'h0}, 16'(r.d ? e[7:0] : r.mv));
         rd(baiu_pkg::OFS_STATUS, 16'(e[12:8]));
      end
      // Unknown opcode and partial byte enables leave the accumulator alone
      wr(baiu_pkg::OFS_ACC, 16'h0033);
      wr(baiu_pkg::OFS_INSTR, 16'h0E55);
      bus(1'h1, baiu_pkg::OFS_INSTR, 16'h0F01, 4'h1);
      rd(baiu_pkg::OFS_ACC, 16'h0033);
      // Back-to-back literal adds accumulate
      wr(baiu_pkg::OFS_INSTR, 16'h0F10);
      wr(baiu_pkg::OFS_INSTR, 16'h0F10);
      rd(baiu_pkg::OFS_ACC, 16'h0053);
      wr(16'h0020, 16'h00AB);
      rd(16'h0020, 16'h0000);
      rst <= 1'h1;
      @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      rd(baiu_pkg::OFS_ACC, 16'h0000);
      rd(baiu_pkg::OFS_CTRL, 16'h0000);
      rd(baiu_pkg::OFS_INDEX, 16'h0000);
      close_out();
   end
endmodule : tb
`default_nettype wire
